// ==== src/rbs_cfg_if.sv ====
/*
  Interface carrying the latched configuration from the loader core to
  the pin steering module.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface rbs_cfg_if;
  logic [1:0] bus_type;      // Live bus type field
  logic [1:0] cs_strap;      // Frozen chip select count
  logic [1:0] seg_strap;     // Frozen segment line count
  logic       done;          // Configuration taken
  modport core  (output bus_type, output cs_strap, output seg_strap, output done);
  modport steer (input  bus_type, input  cs_strap, input  seg_strap, input  done);
endinterface

// ==== src/rbs_pin_steer.sv ====
/*
  Pin steering: turns the latched configuration into port enables for
  the address/data port, the address port, chip selects and segment pins.
  Assumes the configuration interface is driven on the same clock.
*/
`timescale 1ns/1ps
module rbs_pin_steer
  import rbs_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // Configuration
  rbs_cfg_if.steer                  cfg,
  input  wire logic                 byte_enable_disable_bit,
  // Pin function enables
  output logic                      port_one_addr_en,
  output logic                      port_zero_hi_data_en,
  output logic                      high_byte_enable_en,
  output logic [CS_LINES-1:0]       cs_en,
  output logic [SEG_LINES-1:0]      seg_en
);
  // Registered state of the steering logic
  typedef struct packed {
    logic                 p1;
    logic                 hi_data;
    logic                 hbe;
    logic [CS_LINES-1:0]  cs;
    logic [SEG_LINES-1:0] seg;
  } rbs_steer_t;

  rbs_steer_t s_q;   // Current enables
  rbs_steer_t s_d;   // Next enables

  // Decode of chip select count
  function automatic logic [CS_LINES-1:0] cs_dec(input logic [1:0] c);
    unique case (c)
      CSS_FOUR:  cs_dec = 4'h0F;
      CSS_NONE:  cs_dec = 4'h00;
      CSS_TWO:   cs_dec = 4'h03;
      CSS_THREE: cs_dec = 4'h07;
    endcase
  endfunction

  // Decode of segment line count
  function automatic logic [SEG_LINES-1:0] seg_dec(input logic [1:0] c);
    unique case (c)
      SLS_TWO:   seg_dec = 8'h03;
      SLS_MAX:   seg_dec = 8'hFF;
      SLS_NONE:  seg_dec = 8'h00;
      SLS_FOUR:  seg_dec = 8'h0F;
    endcase
  endfunction

  // Next enables from configuration
  always_comb begin
    s_d = '0;
    if (cfg.done) begin
      s_d.p1  = ~cfg.bus_type[0];
      s_d.hi_data = cfg.bus_type[1] | cfg.bus_type[0];
      s_d.hbe     = cfg.bus_type[1] | ~byte_enable_disable_bit;
      s_d.cs  = cs_dec(cfg.cs_strap);
      s_d.seg = seg_dec(cfg.seg_strap);
    end
  end

  // Register the enables
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign port_one_addr_en     = s_q.p1;
  assign port_zero_hi_data_en = s_q.hi_data;
  assign high_byte_enable_en  = s_q.hbe;
  assign cs_en                = s_q.cs;
  assign seg_en               = s_q.seg;

  // Demultiplexed types drive the address port
  property p_p1_demux;
    @(posedge sys_clk) disable iff (!arst_n)
      cfg.done && !cfg.bus_type[0] |=> port_one_addr_en;
  endproperty
  a_p1_demux: assert property (p_p1_demux) else $error("address port not driven");

  // Multiplexed types keep the address port off
  property p_p1_mux;
    @(posedge sys_clk) disable iff (!arst_n)
      cfg.bus_type[0] |=> !port_one_addr_en;
  endproperty
  a_p1_mux: assert property (p_p1_mux) else $error("address port driven in mux");

  // Sixteen bit bus enables high byte enable
  property p_hbe_wide;
    @(posedge sys_clk) disable iff (!arst_n)
      cfg.done && cfg.bus_type[1] |=> high_byte_enable_en;
  endproperty
  a_hbe_wide: assert property (p_hbe_wide) else $error("high byte enable missing");

  // No segment lines on the minimum setting
  property p_seg_none;
    @(posedge sys_clk) disable iff (!arst_n)
      cfg.seg_strap == SLS_NONE |=> seg_en == '0;
  endproperty
  a_seg_none: assert property (p_seg_none) else $error("segment pins enabled");
endmodule

// ==== src/rbs_pkg.sv ====
/*
  Package for the reset bus strap loader: strap positions, field codes,
  decoded counts and reset timing.
  Assumes one system clock at 40 MHz and an active low asynchronous reset.
*/
package rbs_pkg;
  // Clock and timing
  localparam int unsigned SYS_CLK_HZ        = 40000000;
  localparam int unsigned RESET_SEQ_NS      = 1000;
  localparam int unsigned RESET_SEQ_CYCLES  =
    (RESET_SEQ_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned SEQ_CNT_W         = 8;

  // Strap positions in the low byte
  localparam int unsigned BT_WIDTH_BIT      = 7;
  localparam int unsigned BT_MUX_BIT        = 6;
  // Strap positions in the high byte
  localparam int unsigned WRS_BIT           = 0;
  localparam int unsigned CSS_LSB           = 1;
  localparam int unsigned SLS_LSB           = 3;
  localparam int unsigned CLK_LSB           = 5;

  // Bus type codes
  localparam logic [1:0] BT_8_DEMUX         = 2'h0;
  localparam logic [1:0] BT_8_MUX           = 2'h1;
  localparam logic [1:0] BT_16_DEMUX        = 2'h2;
  localparam logic [1:0] BT_16_MUX          = 2'h3;
  localparam logic [1:0] BT_INTERNAL        = 2'h0;

  // Chip select count straps
  localparam logic [1:0] CSS_FOUR           = 2'h3;
  localparam logic [1:0] CSS_NONE           = 2'h2;
  localparam logic [1:0] CSS_TWO            = 2'h1;
  localparam logic [1:0] CSS_THREE          = 2'h0;
  localparam int unsigned CS_LINES          = 4;

  // Segment line count straps
  localparam logic [1:0] SLS_TWO            = 2'h3;
  localparam logic [1:0] SLS_MAX            = 2'h2;
  localparam logic [1:0] SLS_NONE           = 2'h1;
  localparam logic [1:0] SLS_FOUR           = 2'h0;
  localparam int unsigned SEG_LINES         = 8;
  localparam int unsigned ADDR_W            = 24;
  localparam int unsigned SEG_LSB           = 16;

  // Reset values of the held copies (all straps high)
  localparam logic [7:0] STRAP_RST          = 8'hFF;

  // Loader sequence
  typedef enum logic [1:0] {
    RBS_WAIT = 2'b00,
    RBS_SEQ  = 2'b01,
    RBS_DONE = 2'b11
  } rbs_state_t;
endpackage

// ==== src/rbs_top.sv ====
/*
  Reset bus strap loader: samples the strap levels on the address/data
  port at the end of the internal reset sequence and sets up the bus.
  Assumes straps are pulled up inside and held stable by the board until
  the bus is taken, and that external start select is a board pin.
*/
`timescale 1ns/1ps
module rbs_top
  import rbs_pkg::*;
#(
  parameter int unsigned SEQ_CYCLES = RESET_SEQ_CYCLES
)(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // Reset source and start select pins
  input  wire logic                 hw_reset,
  input  wire logic                 external_start_select,
  // Strap pins
  input  wire logic [7:0]           port_zero_low_byte,
  input  wire logic [7:0]           port_zero_high_byte,
  // Software access to the bus type field and the byte enable disable bit
  input  wire logic                 bus_type_wr,
  input  wire logic [1:0]           bus_type_wdata,
  input  wire logic                 byte_enable_disable_bit,
  // Internal bus address
  input  wire logic [ADDR_W-1:0]    cpu_addr,
  // Configuration outputs
  output logic [1:0]                bus_type_field,
  output logic [7:0]                strap_latch_reg,
  output logic                      write_config_bit,
  output logic [2:0]                clock_config_straps,
  output logic                      config_done,
  output logic [ADDR_W-1:0]         full_addr,
  // Pin function enables
  output logic                      port_one_addr_en,
  output logic                      port_zero_hi_data_en,
  output logic                      high_byte_enable_en,
  output logic [CS_LINES-1:0]       cs_en,
  output logic [SEG_LINES-1:0]      seg_en
);
  // Loader state
  typedef struct packed {
    rbs_state_t           st;
    logic [SEQ_CNT_W-1:0] cnt;
    logic [1:0]           btype;
    logic [7:0]           hi;
    logic [2:0]           clk;
    logic                 wcfg;
    logic                 done;
    logic [ADDR_W-1:0]    addr;
  } rbs_core_t;

  rbs_core_t c_q;   // Current state
  rbs_core_t c_d;   // Next state

  // Two-stage synchronisers for the pins
  logic [17:0] sync1_q;   // First stage
  logic [17:0] sync2_q;   // Second stage
  logic [7:0]  lo_s;      // Synchronised low byte
  logic [7:0]  hi_s;      // Synchronised high byte
  logic        ext_s;     // Synchronised start select
  logic        hw_s;      // Synchronised reset source

  // Synchroniser flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= {hw_reset, external_start_select,
                  port_zero_high_byte, port_zero_low_byte};
      sync2_q <= sync1_q;
    end
  end

  // Split the second stage back into its pins
  assign lo_s  = sync2_q[7:0];
  assign hi_s  = sync2_q[15:8];
  assign ext_s = sync2_q[16];
  assign hw_s  = sync2_q[17];

  // Last count of the internal reset sequence
  localparam logic [SEQ_CNT_W-1:0] SEQ_LAST = SEQ_CNT_W'(SEQ_CYCLES - 1);

  // Sequence and capture
  always_comb begin
    c_d      = c_q;
    c_d.addr = cpu_addr;
    unique case (c_q.st)
      // Let synchronisers fill
      RBS_WAIT: begin
        c_d.st = RBS_SEQ;
      end
      // Internal reset sequence
      RBS_SEQ: begin
        if (c_q.cnt == SEQ_LAST) begin
          c_d.st   = RBS_DONE;
          c_d.done = 1'b1;
          if (ext_s) begin
            c_d.btype = {lo_s[BT_WIDTH_BIT], lo_s[BT_MUX_BIT]};
          end else begin
            c_d.btype = BT_INTERNAL;
          end
          c_d.hi   = hi_s;
          c_d.wcfg = ~hi_s[WRS_BIT];
          if (hw_s) begin
            c_d.clk = hi_s[CLK_LSB +: 3];
          end
        end else begin
          c_d.cnt = c_q.cnt + 1'b1;
        end
      end
      // Running: only the bus type field stays writable
      RBS_DONE: begin
        if (bus_type_wr) begin
          c_d.btype = bus_type_wdata;
        end
      end
      default: begin
        c_d.st = RBS_WAIT;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      c_q.st   <= RBS_WAIT;
      c_q.cnt  <= '0;
      c_q.btype <= BT_16_MUX;
      c_q.hi   <= STRAP_RST;
      c_q.clk  <= '1;
      c_q.wcfg <= 1'b0;
      c_q.done <= 1'b0;
      c_q.addr <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // Outputs straight from the core registers
  assign bus_type_field      = c_q.btype;
  assign strap_latch_reg     = c_q.hi;
  assign write_config_bit    = c_q.wcfg;
  assign clock_config_straps = c_q.clk;
  assign config_done         = c_q.done;
  assign full_addr           = c_q.addr;

  // Configuration to pin steering; counts come only from frozen straps
  rbs_cfg_if cfg_i ();
  assign cfg_i.bus_type  = c_q.btype;
  assign cfg_i.cs_strap  = c_q.hi[CSS_LSB +: 2];
  assign cfg_i.seg_strap = c_q.hi[SLS_LSB +: 2];
  assign cfg_i.done      = c_q.done;

  rbs_pin_steer u_steer (
    .sys_clk                 (sys_clk),
    .arst_n                  (arst_n),
    .cfg                     (cfg_i.steer),
    .byte_enable_disable_bit (byte_enable_disable_bit),
    .port_one_addr_en        (port_one_addr_en),
    .port_zero_hi_data_en    (port_zero_hi_data_en),
    .high_byte_enable_en     (high_byte_enable_en),
    .cs_en                   (cs_en),
    .seg_en                  (seg_en)
  );

  // Strap latch holds its value once running
  property p_latch_frozen;
    @(posedge sys_clk) disable iff (!arst_n)
      config_done |=> $stable(strap_latch_reg);
  endproperty
  a_latch_frozen: assert property (p_latch_frozen) else $error("strap latch moved");

  // Write config bit is the inverse of the latched strap
  property p_wcfg;
    @(posedge sys_clk) disable iff (!arst_n)
      config_done |-> write_config_bit == !strap_latch_reg[WRS_BIT];
  endproperty
  a_wcfg: assert property (p_wcfg) else $error("write config not inverse");

  // Software write reaches the bus type field next cycle
  property p_bt_write;
    @(posedge sys_clk) disable iff (!arst_n)
      config_done && bus_type_wr |=> bus_type_field == $past(bus_type_wdata);
  endproperty
  a_bt_write: assert property (p_bt_write) else $error("bus type write lost");

  // Internal start clears the field at capture
  property p_internal;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(config_done) && !$past(ext_s) |-> bus_type_field == BT_INTERNAL;
  endproperty
  a_internal: assert property (p_internal) else $error("bus type not cleared");

  // Capture happens within 300 cycles of reset release
  property p_done_time;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(arst_n) |-> ##[1:300] config_done;
  endproperty
  a_done_time: assert property (p_done_time) else $error("capture too late");

  // Addresses always pass full width
  property p_addr;
    @(posedge sys_clk) disable iff (!arst_n)
      1'b1 |=> full_addr == $past(cpu_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address truncated");

  // Field holds its reset code until the straps are taken
  property p_early_wr;
    @(posedge sys_clk) disable iff (!arst_n)
      !config_done |-> bus_type_field == BT_16_MUX;
  endproperty
  a_early_wr: assert property (p_early_wr) else $error("early bus type change");

  // External start copies the bus type straps
  property p_ext_capture;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(config_done) && $past(ext_s) |->
        bus_type_field == $past(lo_s[BT_WIDTH_BIT:BT_MUX_BIT]);
  endproperty
  a_ext_capture: assert property (p_ext_capture) else $error("bus straps not copied");

  // Upper strap byte lands in the latch
  property p_latch_capture;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(config_done) |-> strap_latch_reg == $past(hi_s);
  endproperty
  a_latch_capture: assert property (p_latch_capture) else $error("strap byte not latched");

  // Hardware reset takes the clock straps
  property p_clk_hw;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(config_done) && $past(hw_s) |->
        clock_config_straps == $past(hi_s[CLK_LSB +: 3]);
  endproperty
  a_clk_hw: assert property (p_clk_hw) else $error("clock straps not taken");

  // Other resets leave the clock straps alone
  property p_clk_soft;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(config_done) && !$past(hw_s) |->
        clock_config_straps == $past(clock_config_straps);
  endproperty
  a_clk_soft: assert property (p_clk_soft) else $error("clock straps re-read");

  // Clock straps never move once running
  property p_clk_frozen;
    @(posedge sys_clk) disable iff (!arst_n)
      config_done |=> $stable(clock_config_straps);
  endproperty
  a_clk_frozen: assert property (p_clk_frozen) else $error("clock straps moved");

  // Write config bit never moves once running
  property p_wcfg_frozen;
    @(posedge sys_clk) disable iff (!arst_n)
      config_done |=> $stable(write_config_bit);
  endproperty
  a_wcfg_frozen: assert property (p_wcfg_frozen) else $error("write config moved");

  // Chip select enables fixed once settled
  property p_cs_frozen;
    @(posedge sys_clk) disable iff (!arst_n)
      config_done && $past(config_done) |=> $stable(cs_en);
  endproperty
  a_cs_frozen: assert property (p_cs_frozen) else $error("chip select count moved");

  // Segment enables fixed once settled
  property p_seg_frozen;
    @(posedge sys_clk) disable iff (!arst_n)
      config_done && $past(config_done) |=> $stable(seg_en);
  endproperty
  a_seg_frozen: assert property (p_seg_frozen) else $error("segment count moved");

  // Once running, the field only changes on a software write
  property p_bt_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      config_done && !bus_type_wr |=> $stable(bus_type_field);
  endproperty
  a_bt_hold: assert property (p_bt_hold) else $error("bus type moved unasked");

  // Capture only at the last count of the sequence
  property p_seq_len;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(config_done) |-> $past(c_q.cnt) == SEQ_LAST;
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("capture at wrong count");

  // Configuration stays taken until the next reset
  property p_done_once;
    @(posedge sys_clk) disable iff (!arst_n)
      config_done |=> config_done;
  endproperty
  a_done_once: assert property (p_done_once) else $error("configuration dropped");
endmodule

// ==== tb/rbs_board.sv ====
/*
  Board model: strap pull-downs against the internal pull-ups, then bus
  traffic on the same pins once the device has taken the bus.
  Assumes config_done marks the moment the bus is taken.
*/
`timescale 1ns/1ps
module rbs_board (
  // Clock and bus ownership
  input  wire logic       sys_clk,
  input  wire logic       bus_taken,
  // Pull-down fitting, one bit a pin
  input  wire logic [7:0] pd_low,
  input  wire logic [7:0] pd_high,
  // Strap pins
  output logic      [7:0] port_zero_low_byte,
  output logic      [7:0] port_zero_high_byte
);
  // Traffic pattern that changes every cycle
  logic [7:0] traffic_q = 8'h00;

  // Step the traffic pattern
  always_ff @(posedge sys_clk) begin
    traffic_q <= traffic_q + 8'h5B;
  end

  // Open pins read high, fitted pull-downs read low
  always_comb begin
    if (!bus_taken) begin
      port_zero_low_byte  = ~pd_low;
      port_zero_high_byte = ~pd_high;
    end else begin
      // Straps no longer held: pins carry bus traffic
      port_zero_low_byte  = traffic_q;
      port_zero_high_byte = ~traffic_q;
    end
  end
endmodule

// ==== tb/testbench.sv ====
/*
  Testbench for the reset bus strap loader: boots under many strap
  fittings and checks the configuration outputs and pin enables.
  Assumes a 40 MHz clock and a short reset sequence for simulation.
*/
`timescale 1ns/1ps
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, act, exp); end end
module testbench;
  import rbs_pkg::*;
  // Design signals
  logic              sys_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              hw_reset = 1'b1;
  logic              ext_sel = 1'b1;
  logic [7:0]        pin_lo, pin_hi, pd_low = 8'h00, pd_high = 8'h00;
  logic              bus_type_wr = 1'b0;
  logic [1:0]        bus_type_wdata = 2'h0;
  logic              byte_dis = 1'b0;
  logic [ADDR_W-1:0] cpu_addr = '0;
  logic [1:0]        bus_type_field;
  logic [7:0]        strap_latch_reg;
  logic              write_config_bit, config_done, port_one_addr_en;
  logic [2:0]        clock_config_straps;
  logic [ADDR_W-1:0] full_addr;
  logic              port_zero_hi_data_en, high_byte_enable_en;
  logic [3:0]        cs_en;
  logic [7:0]        seg_en;
  int                mismatches = 0;
  int                n_compared = 0;
  // Expected decodes, indexed by strap code
  logic [3:0]        cs_exp [4] = '{4'h7, 4'h3, 4'h0, 4'hF};
  logic [7:0]        seg_exp [4] = '{8'h0F, 8'h00, 8'hFF, 8'h03};

  // Clock at 25 ns
  always #12.5 sys_clk = ~sys_clk;

  // Design with a short reset sequence
  rbs_top #(.SEQ_CYCLES(4)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .hw_reset(hw_reset),
    .external_start_select(ext_sel), .port_zero_low_byte(pin_lo),
    .port_zero_high_byte(pin_hi), .bus_type_wr(bus_type_wr),
    .bus_type_wdata(bus_type_wdata), .byte_enable_disable_bit(byte_dis),
    .cpu_addr(cpu_addr), .bus_type_field(bus_type_field),
    .strap_latch_reg(strap_latch_reg), .write_config_bit(write_config_bit),
    .clock_config_straps(clock_config_straps), .config_done(config_done),
    .full_addr(full_addr), .port_one_addr_en(port_one_addr_en),
    .port_zero_hi_data_en(port_zero_hi_data_en),
    .high_byte_enable_en(high_byte_enable_en), .cs_en(cs_en), .seg_en(seg_en)
  );

  // Board straps and bus traffic
  rbs_board board_u (
    .sys_clk(sys_clk), .bus_taken(config_done), .pd_low(pd_low),
    .pd_high(pd_high), .port_zero_low_byte(pin_lo), .port_zero_high_byte(pin_hi)
  );

  // Step n edges, land just after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Reset with given fitting, return once the configuration is taken
  task automatic boot(input logic [7:0] lo, input logic [7:0] hi, input logic ext,
                      input logic hw);
    pd_low   = lo;
    pd_high  = hi;
    ext_sel  = ext;
    hw_reset = hw;
    arst_n   = 1'b0;
    tick(6);
    arst_n = 1'b1;
    for (int i = 0; i < 100 && config_done !== 1'b1; i++) tick(1);
    `CHK(config_done, 1'b1)
  endtask

  // Every bus, chip select and segment code from the straps
  task automatic t_codes;
    logic [1:0] c;
    logic [7:0] hv;
    for (int i = 0; i < 4; i++) begin
      c        = i[1:0];
      hv       = {c[0], c[1], c[0], c, c, c[1]};
      byte_dis = c[0];
      boot({~c, 6'h00}, ~hv, 1'b1, 1'b1);
      tick(2);
      `CHK(bus_type_field, c)
      `CHK(strap_latch_reg, hv)
      `CHK(write_config_bit, ~c[1])
      `CHK(clock_config_straps, hv[7:5])
      `CHK(cs_en, cs_exp[i])
      `CHK(seg_en, seg_exp[i])
      `CHK(port_one_addr_en, ~c[0])
      `CHK(port_zero_hi_data_en, c[1] | c[0])
      `CHK(high_byte_enable_en, c[1] | ~c[0])
    end
  endtask

  // Internal start clears the field; soft reset keeps clock straps at reset value
  task automatic t_start_and_soft;
    boot(8'h00, 8'h00, 1'b0, 1'b1);
    tick(2);
    `CHK(bus_type_field, BT_INTERNAL)
    boot(8'h00, 8'hE0, 1'b1, 1'b0);
    tick(2);
    `CHK(clock_config_straps, 3'h7)
    `CHK(strap_latch_reg, 8'h1F)
  endtask

  // Refused early write, back-to-back writes, fixed counts, full address
  task automatic t_write;
    bus_type_wr    = 1'b1;
    bus_type_wdata = BT_8_DEMUX;
    boot(8'h00, 8'h00, 1'b1, 1'b1);
    bus_type_wr = 1'b0;
    tick(2);
    `CHK(bus_type_field, BT_16_MUX)
    bus_type_wr    = 1'b1;
    bus_type_wdata = BT_8_MUX;
    tick(1);
    bus_type_wdata = BT_16_DEMUX;
    cpu_addr       = 24'hA5_C3F1;
    tick(1);
    bus_type_wr = 1'b0;
    `CHK(full_addr, 24'hA5_C3F1)
    `CHK(bus_type_field, BT_16_DEMUX)
    tick(1);
    `CHK(port_one_addr_en, 1'b1)
    `CHK(cs_en, 4'hF)
    `CHK(seg_en, 8'h03)
  endtask

  // Verdict and end of run
  task automatic finish_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_codes();
    t_start_and_soft();
    t_write();
    finish_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(5000 * 25);
    mismatches++;
    finish_test();
  end
endmodule
